// *** design/byte_fifo.v ***
// 64-byte flip-flop fifo with clear, fill count and head output
`include "radio_fifo_consts.vh"
module byte_fifo (
  input  wire       clock,  // core clock
  input  wire       rstn,   // synchronous reset, active low
  input  wire       clr,    // hold empty while high
  input  wire       push,   // write din
  input  wire [7:0] din,    // byte in
  input  wire       pop,    // drop head
  output wire [7:0] dout,   // head byte
  output wire       full,   // no room
  output wire       empty,  // no data
  output reg  [6:0] count   // bytes held
);
  reg [7:0] mem [0:63];
  reg [5:0] wr_ptr;
  reg [5:0] rd_ptr;
  wire      do_push = push & ~full & ~clr;
  wire      do_pop  = pop & ~empty & ~clr;

  assign dout  = mem[rd_ptr];
  assign full  = (count == `FIFO_DEPTH);
  assign empty = (count == 7'h00);

  // storage needs no reset, only the pointers and count do
  always @(posedge clock) begin
    if (do_push) mem[wr_ptr] <= din;
  end

  // pointers and count; clear dominates any access
  always @(posedge clock) begin
    if (!rstn || clr) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      count  <= 7'h00;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 6'h01;
      if (do_pop) rd_ptr <= rd_ptr + 6'h01;
      if (do_push && !do_pop) count <= count + 7'h01;
      else if (do_pop && !do_push) count <= count - 7'h01;
    end
  end
endmodule // byte_fifo

// *** design/radio_fifo_consts.vh ***
// register map, field positions, reset values and state codes of the block
`ifndef RADIO_FIFO_CONSTS_VH
`define RADIO_FIFO_CONSTS_VH
// register addresses
`define A_INT_STATUS 8'h03
`define A_INT_ENABLE 8'h05
`define A_OP_MODE    8'h07
`define A_ACCESS_CTL 8'h30
`define A_HDR_CTL2   8'h33
`define A_PRE_LEN    8'h34
`define A_SYNC_FIRST 8'h36
`define A_SYNC_LAST  8'h39
`define A_TXHD_FIRST 8'h3A
`define A_TXHD_LAST  8'h3D
`define A_TX_LEN     8'h3E
`define A_RX_LEN     8'h4B
`define A_TX_AF      8'h7C
`define A_TX_AE      8'h7D
`define A_RX_AF      8'h7E
`define A_FIFO       8'h7F
`define A_FUNC_CTL2  8'h80
// reset values
`define RST_ACCESS   8'h8D
`define RST_HDR2     8'h22
`define RST_PRE      8'h08
`define RST_SYNC     32'h2DD40000
`define RST_TX_AF    6'h37
`define RST_TX_AE    6'h04
`define RST_RX_AF    6'h37
// operating mode bits
`define B_XTON       0
`define B_PLLON      1
`define B_RXON       2
`define B_TXON       3
// access control bits
`define B_ENPACRX    7
`define B_CRCDONLY   5
`define B_ENPACTX    3
`define B_ENCRC      2
// header control 2 bits
`define B_FIXPKLEN   3
// function control 2 bits
`define B_CLR_TX     0
`define B_CLR_RX     1
`define B_RXMPK      4
// status and enable bits
`define B_CRCERR     0
`define B_PKVALID    1
`define B_PKSENT     2
`define B_RXAF       4
`define B_TXAE       5
`define B_TXAF       6
// operating states
`define S_STANDBY    3'h0
`define S_READY      3'h1
`define S_TUNE       3'h2
`define S_TX         3'h3
`define S_RX         3'h4
// transmit sequencer states
`define T_IDLE       3'h0
`define T_PRE        3'h1
`define T_SYNC       3'h2
`define T_HDR        3'h3
`define T_LEN        3'h4
`define T_DATA       3'h5
`define T_CRC        3'h6
`define T_DONE       3'h7
// receive sequencer states
`define R_IDLE       3'h0
`define R_HDR        3'h1
`define R_LEN        3'h2
`define R_DATA       3'h3
`define R_CRC        3'h4
`define R_END        3'h5
// fifo geometry, preamble pattern and crc
`define FIFO_DEPTH   7'h40
`define PRE_BYTE     8'h55
`define CRC_INIT     16'hFFFF
`define CRC_POLY     16'h1021
`endif

// *** design/radio_fifo_packet_handler.v ***
// fifo and packet handler core of the radio transceiver
//
// Contract
// [RULE1] separate 64-byte receive and transmit fifos
// [RULE2] writes to the fifo address push tx, reads there pop rx
// [RULE3] tx almost-full event when fill reaches six-bit threshold
// [RULE4] tx almost-empty event when fill drops below threshold while sending
// [RULE5] after packet sent, clear tx bit and fall to mode from other bits
// [RULE6] synthesizer bit set on tx entry returns to tune
// [RULE7] tx bit alone returns to ready, oscillator kept on
// [RULE8] host writes zero to operating mode to reach standby
// [RULE9] rx almost-full event on the interrupt pin; host then reads
// [RULE10] each fifo has its own clear bit, tx bit 0, rx bit 1
// [RULE11] enables gate only the pin; status bits always set
// [RULE12] with length set, send that many payload bytes then packet sent
// [RULE13] host re-enters tx to send remaining fifo bytes
// [RULE14] preamble is alternating bits starting with zero
// [RULE15] packet fields added automatically, tx and rx enabled apart
// [RULE16] rx handler off: raw bytes after sync go to the fifo
// [RULE17] handler off: no crc or header processing; tx still sends crc after the data when crc is enabled
// [RULE18] tx header and length fields come from registers
// [RULE19] rx fixed or variable length; multi-packet option stores fields
// [RULE20] crc covers data only or data plus header and length
// [RULE21] clear empties fifo, resets pointers and threshold state
// [RULE22] threshold events fire once per crossing
`include "radio_fifo_consts.vh"
module radio_fifo_packet_handler (
  input  wire       clock,           // 50 mhz core clock
  input  wire       rstn,            // synchronous reset, active low
  input  wire [7:0] reg_addr,        // register address
  input  wire       reg_wr,          // write strobe, one cycle
  input  wire       reg_rd,          // read strobe, one cycle
  input  wire [7:0] reg_wdata,       // write data
  output reg  [7:0] reg_rdata,       // read data, next cycle
  output wire [7:0] tx_byte,         // byte to modulator
  output wire       tx_valid,        // tx_byte is valid
  input  wire       tx_ready,        // modulator takes byte
  input  wire [7:0] rx_byte,         // byte from demodulator
  input  wire       rx_valid,        // rx_byte strobe
  input  wire       rx_frame,        // high after sync until frame end
  output reg        interrupt_out_n, // interrupt pin, active low
  output reg  [2:0] op_state         // current operating state
);
  // register file
  reg  [7:0]  int_status;
  reg  [7:0]  int_enable;
  reg  [7:0]  op_mode;
  reg  [7:0]  access_ctl;
  reg  [7:0]  hdr_ctl2;
  reg  [7:0]  pre_len;
  reg  [31:0] sync_word;
  reg  [31:0] tx_header;
  reg  [7:0]  tx_len;
  reg  [7:0]  rx_len;
  reg  [5:0]  tx_af_lvl;
  reg  [5:0]  tx_ae_lvl;
  reg  [5:0]  rx_af_lvl;
  reg  [7:0]  func_ctl2;
  // sequencers
  reg  [2:0]  t_state;
  reg  [8:0]  cnt;
  reg  [15:0] tcrc;
  reg  [2:0]  t_next;
  reg  [8:0]  t_len;
  reg  [7:0]  t_byte;
  reg  [2:0]  r_state;
  reg  [8:0]  rcnt;
  reg  [15:0] rcrc;
  reg  [2:0]  r_next;
  reg  [8:0]  r_len;
  reg         tx_af_q;
  reg         tx_ae_q;
  reg         rx_af_q;
  wire [7:0]  tx_dout;
  wire [7:0]  rx_dout;
  wire [6:0]  tx_count;
  wire [6:0]  rx_count;
  wire        tx_full;
  wire        tx_empty;
  wire        rx_full;
  wire        rx_empty;
  wire        buf_ready;
  wire        tx_pop;
  wire        pk_sent;
  wire        rx_push;

  // crc-16 over one byte, msb first
  function [15:0] crc16;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (r[15] ^ d[i]) r = {r[14:0], 1'b0} ^ `CRC_POLY;
        else r = {r[14:0], 1'b0};
      end
      crc16 = r;
    end
  endfunction

  // decoded controls
  wire       fifo_wr   = reg_wr & (reg_addr == `A_FIFO);
  wire       fifo_rd   = reg_rd & (reg_addr == `A_FIFO);
  wire       clr_tx    = func_ctl2[`B_CLR_TX];
  wire       clr_rx    = func_ctl2[`B_CLR_RX];
  wire       ph_tx     = access_ctl[`B_ENPACTX];
  wire       ph_rx     = access_ctl[`B_ENPACRX];
  wire       crc_on    = access_ctl[`B_ENCRC];
  wire       crc_donly = access_ctl[`B_CRCDONLY];
  wire       fix_len   = hdr_ctl2[`B_FIXPKLEN];
  wire       multi     = func_ctl2[`B_RXMPK];
  wire [2:0] hd_n      = hdr_ctl2[6] ? 3'h4 : hdr_ctl2[6:4];
  wire [8:0] pre_nib   = {hdr_ctl2[0], pre_len};
  wire [9:0] pre_sum   = {1'b0, pre_nib} + 10'h001;
  wire [8:0] pre_bytes = pre_sum[9:1];
  wire [8:0] sync_n    = {7'h00, hdr_ctl2[2:1]} + 9'h001;
  // byte lane of a 32-bit field, first address is the top byte
  wire [1:0] widx      = reg_addr[1:0] + 2'h2;
  wire [4:0] w_sel     = 5'h18 - {widx, 3'h0};
  wire [4:0] t_sel     = 5'h18 - {cnt[1:0], 3'h0};
  wire       in_sync   = (reg_addr >= `A_SYNC_FIRST) &&
                         (reg_addr <= `A_SYNC_LAST);
  wire       in_txhd   = (reg_addr >= `A_TXHD_FIRST) &&
                         (reg_addr <= `A_TXHD_LAST);

  // [RULE1] two fifos
  // [RULE2] shared access address
  // [RULE10] separate clears
  byte_fifo tx_fifo (
    .clock (clock),
    .rstn  (rstn),
    .clr   (clr_tx),
    .push  (fifo_wr),
    .din   (reg_wdata),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .full  (tx_full),
    .empty (tx_empty),
    .count (tx_count)
  );
  byte_fifo rx_fifo (
    .clock (clock),
    .rstn  (rstn),
    .clr   (clr_rx),
    .push  (rx_push),
    .din   (rx_byte),
    .pop   (fifo_rd),
    .dout  (rx_dout),
    .full  (rx_full),
    .empty (rx_empty),
    .count (rx_count)
  );

  // plain configuration writes
  always @(posedge clock) begin
    if (!rstn) begin
      int_enable <= 8'h00;
      access_ctl <= `RST_ACCESS;
      hdr_ctl2   <= `RST_HDR2;
      pre_len    <= `RST_PRE;
      sync_word  <= `RST_SYNC;
      tx_header  <= 32'h00000000;
      tx_len     <= 8'h00;
      tx_af_lvl  <= `RST_TX_AF;
      tx_ae_lvl  <= `RST_TX_AE;
      rx_af_lvl  <= `RST_RX_AF;
      func_ctl2  <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `A_INT_ENABLE: int_enable <= reg_wdata;
        `A_ACCESS_CTL: access_ctl <= reg_wdata;
        `A_HDR_CTL2:   hdr_ctl2   <= reg_wdata;
        `A_PRE_LEN:    pre_len    <= reg_wdata;
        `A_TX_LEN:     tx_len     <= reg_wdata;
        `A_TX_AF:      tx_af_lvl  <= reg_wdata[5:0];
        `A_TX_AE:      tx_ae_lvl  <= reg_wdata[5:0];
        `A_RX_AF:      rx_af_lvl  <= reg_wdata[5:0];
        `A_FUNC_CTL2:  func_ctl2  <= reg_wdata;
        default: ;
      endcase
      if (in_sync) sync_word[w_sel +: 8] <= reg_wdata;
      // [RULE18] header from registers
      if (in_txhd) tx_header[w_sel +: 8] <= reg_wdata;
    end
  end

  // [RULE5] packet sent ends transmit
  // [RULE6] synthesizer bit selects tune
  // [RULE7] otherwise ready, never standby
  // [RULE13] only a new write re-enters transmit
  always @(posedge clock) begin
    if (!rstn) begin
      op_mode  <= 8'h00;
      op_state <= `S_STANDBY;
    end else if (reg_wr && reg_addr == `A_OP_MODE) begin
      op_mode  <= reg_wdata;
      op_state <= reg_wdata[`B_TXON]  ? `S_TX :
                  reg_wdata[`B_RXON]  ? `S_RX :
                  reg_wdata[`B_PLLON] ? `S_TUNE :
                  reg_wdata[`B_XTON]  ? `S_READY : `S_STANDBY;
    end else if (pk_sent) begin
      op_mode[`B_TXON] <= 1'b0;
      op_state <= op_mode[`B_PLLON] ? `S_TUNE : `S_READY;
    end
  end

  // transmit field table: each state has a length and a byte source
  always @* begin
    t_len  = 9'h000;
    t_byte = `PRE_BYTE;
    t_next = `T_DONE;
    case (t_state)
      // [RULE14] alternating preamble, zero first
      `T_PRE: begin
        t_len  = pre_bytes;
        t_next = `T_SYNC;
      end
      // [RULE15] fields added when enabled
      `T_SYNC: begin
        t_len  = sync_n;
        t_byte = sync_word[t_sel +: 8];
        t_next = ph_tx ? `T_HDR : `T_DATA;
      end
      `T_HDR: begin
        t_len  = {6'h00, hd_n};
        t_byte = tx_header[t_sel +: 8];
        t_next = fix_len ? `T_DATA : `T_LEN;
      end
      `T_LEN: begin
        t_len  = 9'h001;
        t_byte = tx_len;
        t_next = `T_DATA;
      end
      // [RULE12] exact payload count
      `T_DATA: begin
        t_len  = {1'b0, tx_len};
        t_byte = tx_dout;
        t_next = crc_on ? `T_CRC : `T_DONE;
      end
      `T_CRC: begin
        t_len  = 9'h002;
        t_byte = cnt[0] ? tcrc[7:0] : tcrc[15:8];
        t_next = `T_DONE;
      end
      default: t_next = `T_DONE;
    endcase
  end

  // [RULE17] without handler, send fifo until empty, then crc if enabled
  wire t_raw   = (t_state == `T_DATA) & ~ph_tx;
  wire t_end   = t_raw ? tx_empty : (cnt == t_len);
  wire t_busy  = (t_state != `T_IDLE) & (t_state != `T_DONE);
  wire t_valid = t_busy & ~t_end & ~((t_state == `T_DATA) & tx_empty);
  wire t_go    = t_valid & buf_ready;
  assign tx_pop  = t_go & (t_state == `T_DATA);
  assign pk_sent = (t_state == `T_DONE);
  // [RULE20] crc coverage choice
  wire t_cover = (t_state == `T_DATA) | (~crc_donly &
                 ((t_state == `T_HDR) | (t_state == `T_LEN)));

  // transmit sequencer; with the tx handler on, an empty fifo mid-payload simply waits
  always @(posedge clock) begin
    if (!rstn) begin
      t_state <= `T_IDLE;
      cnt     <= 9'h000;
      tcrc    <= `CRC_INIT;
    end else begin
      case (t_state)
        `T_IDLE: begin
          if (op_state == `S_TX) t_state <= `T_PRE;
          cnt  <= 9'h000;
          tcrc <= `CRC_INIT;
        end
        `T_DONE: t_state <= `T_IDLE;
        default: begin
          if (t_end) begin
            t_state <= t_next;
            cnt     <= 9'h000;
          end else if (t_go) begin
            cnt <= cnt + 9'h001;
          end
          if (t_go && t_cover) tcrc <= crc16(tcrc, t_byte);
        end
      endcase
    end
  end

  // buffer lets the modulator stall without losing a byte
  two_entry_buffer tx_buf (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (t_valid),
    .in_ready  (buf_ready),
    .in_data   (t_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_byte)
  );

  // receive field table
  always @* begin
    r_len  = 9'h000;
    r_next = `R_END;
    case (r_state)
      `R_HDR: begin
        r_len  = {6'h00, hd_n};
        r_next = fix_len ? `R_DATA : `R_LEN;
      end
      `R_LEN: begin
        r_len  = 9'h001;
        r_next = `R_DATA;
      end
      `R_DATA: begin
        r_len  = {1'b0, rx_len};
        r_next = crc_on ? `R_CRC : `R_END;
      end
      `R_CRC: begin
        r_len  = 9'h002;
        r_next = `R_END;
      end
      default: r_next = `R_END;
    endcase
  end

  wire r_act   = (op_state == `S_RX) & rx_frame;
  wire r_go    = r_act & rx_valid;
  wire r_field = (r_state == `R_HDR) | (r_state == `R_LEN);
  // [RULE16] raw mode never ends a field, every byte is stored
  wire r_raw   = (r_state == `R_DATA) & ~ph_rx;
  wire r_end   = r_act & ~r_raw & (r_state != `R_IDLE) &
                 (r_state != `R_END) & (rcnt == r_len);
  // [RULE19] multi-packet keeps header and length bytes too
  assign rx_push = r_go & ~r_end & ~clr_rx &
                 ((r_state == `R_DATA) | (r_field & multi));
  wire r_cover = (r_state == `R_DATA) | (r_state == `R_CRC) |
                 (r_field & ~crc_donly);
  // crc over data and the sent crc leaves a zero remainder
  wire ev_valid = r_end & (((r_state == `R_DATA) & ~crc_on) |
                  ((r_state == `R_CRC) & (rcrc == 16'h0000)));
  wire ev_crc   = r_end & (r_state == `R_CRC) & (rcrc != 16'h0000);

  // receive sequencer; a dropped frame aborts to idle
  always @(posedge clock) begin
    if (!rstn) begin
      r_state <= `R_IDLE;
      rcnt    <= 9'h000;
      rcrc    <= `CRC_INIT;
      rx_len  <= 8'h00;
    end else if (!r_act) begin
      r_state <= `R_IDLE;
    end else begin
      case (r_state)
        `R_IDLE: begin
          rcnt <= 9'h000;
          rcrc <= `CRC_INIT;
          if (fix_len) rx_len <= tx_len;
          if (!ph_rx) r_state <= `R_DATA;
          else if (hd_n != 3'h0) r_state <= `R_HDR;
          else r_state <= fix_len ? `R_DATA : `R_LEN;
        end
        `R_END: r_state <= `R_END;
        default: begin
          if (r_end) begin
            r_state <= r_next;
            rcnt    <= 9'h000;
          end else if (r_go) begin
            rcnt <= rcnt + 9'h001;
            if (r_state == `R_LEN) rx_len <= rx_byte;
            if (r_cover) rcrc <= crc16(rcrc, rx_byte);
          end
        end
      endcase
    end
  end

  // [RULE3] tx almost full
  // [RULE4] tx almost empty
  // [RULE9] rx almost full
  wire tx_af_c = (tx_count >= {1'b0, tx_af_lvl});
  wire tx_ae_c = (tx_count <  {1'b0, tx_ae_lvl});
  wire rx_af_c = (rx_count >= {1'b0, rx_af_lvl});
  wire ev_txaf = tx_af_c & ~tx_af_q & ~clr_tx;
  wire ev_txae = tx_ae_c & ~tx_ae_q & ~clr_tx & t_busy;
  wire ev_rxaf = rx_af_c & ~rx_af_q & ~clr_rx;

  // [RULE22] edge flags fire once per crossing
  // [RULE21] clear drops threshold state
  always @(posedge clock) begin
    if (!rstn) begin
      tx_af_q <= 1'b0;
      tx_ae_q <= 1'b0;
      rx_af_q <= 1'b0;
    end else begin
      tx_af_q <= tx_af_c & ~clr_tx;
      tx_ae_q <= tx_ae_c & ~clr_tx & t_busy;
      rx_af_q <= rx_af_c & ~clr_rx;
    end
  end

  wire [7:0] ev = {1'b0, ev_txaf, ev_txae, ev_rxaf, 1'b0,
                   pk_sent, ev_valid, ev_crc};
  wire       st_rd = reg_rd & (reg_addr == `A_INT_STATUS);
  wire [7:0] next_status = (int_status & {8{~st_rd}}) | ev;

  // [RULE11] status always latches; enable only gates the pin
  // read clears, but an event in that same cycle survives
  always @(posedge clock) begin
    if (!rstn) begin
      int_status      <= 8'h00;
      interrupt_out_n <= 1'b1;
    end else begin
      int_status      <= next_status;
      interrupt_out_n <= ~|(next_status & int_enable);
    end
  end

  // register read mux; the fifo address returns the rx head
  always @(posedge clock) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `A_INT_STATUS: reg_rdata <= int_status;
        `A_INT_ENABLE: reg_rdata <= int_enable;
        `A_OP_MODE:    reg_rdata <= op_mode;
        `A_ACCESS_CTL: reg_rdata <= access_ctl;
        `A_HDR_CTL2:   reg_rdata <= hdr_ctl2;
        `A_PRE_LEN:    reg_rdata <= pre_len;
        `A_TX_LEN:     reg_rdata <= tx_len;
        `A_RX_LEN:     reg_rdata <= rx_len;
        `A_TX_AF:      reg_rdata <= {2'h0, tx_af_lvl};
        `A_TX_AE:      reg_rdata <= {2'h0, tx_ae_lvl};
        `A_RX_AF:      reg_rdata <= {2'h0, rx_af_lvl};
        `A_FUNC_CTL2:  reg_rdata <= func_ctl2;
        `A_FIFO:       reg_rdata <= rx_empty ? 8'h00 : rx_dout;
        default: begin
          if (in_sync) reg_rdata <= sync_word[w_sel +: 8];
          else if (in_txhd) reg_rdata <= tx_header[w_sel +: 8];
          else reg_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule // radio_fifo_packet_handler

// *** design/two_entry_buffer.v ***
// two-entry valid/ready buffer with registered outputs
module two_entry_buffer (
  input  wire       clock,      // core clock
  input  wire       rstn,       // synchronous reset, active low
  input  wire       in_valid,   // producer has a byte
  output wire       in_ready,   // room for a byte
  input  wire [7:0] in_data,    // producer byte
  output reg        out_valid,  // byte on out_data
  input  wire       out_ready,  // consumer takes it
  output reg  [7:0] out_data    // head byte
);
  reg [7:0] spare;
  reg       spare_valid;

  // ready depends on flops only, so no combinational path through
  assign in_ready = ~spare_valid;

  // head moves when empty or taken; spare catches a stalled arrival
  always @(posedge clock) begin
    if (!rstn) begin
      out_valid   <= 1'b0;
      out_data    <= 8'h00;
      spare       <= 8'h00;
      spare_valid <= 1'b0;
    end else if (out_ready || !out_valid) begin
      if (spare_valid) begin
        out_data    <= spare;
        out_valid   <= 1'b1;
        spare_valid <= 1'b0;
      end else begin
        out_valid <= in_valid;
        out_data  <= in_data;
      end
    end else if (in_valid && !spare_valid) begin
      spare       <= in_data;
      spare_valid <= 1'b1;
    end
  end
endmodule // two_entry_buffer

// *** tb/modem_model.sv ***
// modulator and demodulator stand-in at the far side of the block
module modem_model (
  input  wire logic       clock,    // core clock
  input  wire logic [7:0] tx_byte,  // byte from block
  input  wire logic       tx_valid, // byte valid
  output logic            tx_ready, // takes byte
  output logic      [7:0] rx_byte,  // byte to block
  output logic            rx_valid, // byte strobe
  output logic            rx_frame  // frame after sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    tx_ready = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_frame = 1'b0;
  end
  // stall one cycle in four so the buffer must hold its byte
  always @(posedge clock) begin
    cnt <= cnt + 2'h1;
    tx_ready <= cnt != 2'h3;
  end
  // frame level, then two cycles of settle time
  task automatic frame(input logic f);
    @(posedge clock);
    rx_frame <= f;
    repeat (2) @(posedge clock);
  endtask
  // one byte, then the line shows garbage, one cycle apart
  task automatic send(input logic [7:0] d);
    @(posedge clock);
    rx_byte <= d;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_byte <= ~d;
  endtask
endmodule // modem_model

// *** tb/radio_fifo_properties.sv ***
// port-level assertions for the fifo and packet handler
module radio_fifo_properties (
  input wire logic       clock,           // core clock
  input wire logic       rstn,            // sync reset, active low
  input wire logic [7:0] reg_addr,        // register address
  input wire logic       reg_wr,          // write strobe
  input wire logic       reg_rd,          // read strobe
  input wire logic [7:0] reg_wdata,       // write data
  input wire logic [7:0] reg_rdata,       // read data
  input wire logic [7:0] tx_byte,         // byte to modulator
  input wire logic       tx_valid,        // byte valid
  input wire logic       tx_ready,        // modulator takes it
  input wire logic       interrupt_out_n, // interrupt pin
  input wire logic [2:0] op_state         // operating state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // mode write that starts a transmission
  sequence s_enter;
    reg_wr && reg_addr == 8'h07 && reg_wdata[3];
  endsequence
  // modulator holding off a pending byte
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  a_preamble_first: assert property (
    s_enter |-> ##[2:8] (tx_valid && tx_byte == 8'h55))
    else $error("no preamble byte after tx entry");
  a_tx_hold: assert property (
    s_stall |=> tx_valid && $stable(tx_byte))
    else $error("stalled tx byte changed");
  a_mode_tx: assert property (
    s_enter |=> op_state == 3'h3) else $error("tx state not entered");
  a_no_standby: assert property (
    $past(op_state) == 3'h3 && op_state != 3'h3 && !$past(reg_wr)
    |-> op_state != 3'h0) else $error("tx fell to standby");
  a_to_standby: assert property (
    reg_wr && reg_addr == 8'h07 && reg_wdata == 8'h00 |=> op_state == 3'h0)
    else $error("zero mode write missed standby");
  a_pin_gated: assert property (
    reg_wr && reg_addr == 8'h05 && reg_wdata == 8'h00 |-> ##2 interrupt_out_n)
    else $error("pin low with enables cleared");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // radio_fifo_properties

// *** tb/testbench.sv ***
// self-checking bench for the fifo and packet handler
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rstn, reg_wr, reg_rd, pend;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_byte, rx_byte, b;
  logic       tx_valid, tx_ready, rx_valid, rx_frame, interrupt_out_n;
  logic [2:0] op_state;
  logic [31:0] seed = 32'd62340;
  int         err_count = 0, n_tests = 0, i;
  logic [7:0] rq[$], tq[$], pq[$], sq[$];
  logic [7:0] regs[7] = '{8'h7C, 8'h7D, 8'h7E, 8'h80, 8'h30, 8'h33, 8'hFF};
  logic [7:0] rsts[7] = '{8'h37, 8'h04, 8'h37, 8'h00, 8'h8D, 8'h22, 8'h00};
  radio_fifo_packet_handler radio_fifo_packet_handler_i (.clock(clock),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_frame(rx_frame),
    .interrupt_out_n(interrupt_out_n), .op_state(op_state));
  modem_model modem_model_i (.clock(clock), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_frame(rx_frame));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    rq.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic push(input int n);
    repeat (n) begin
      b = rnd();
      pq.push_back(b);
      wr(8'h7F, b);
    end
  endtask
  // preamble, sync, then n payload bytes
  task automatic tx(input logic [7:0] m, input logic [2:0] st, input int n);
    repeat (4) tq.push_back(8'h55);
    tq.push_back(8'h2D);
    tq.push_back(8'hD4);
    repeat (n) tq.push_back(pq.pop_front());
    wr(8'h07, m);
    for (i = 0; i < 400 && !(tq.size() == 0 && op_state === st); i++)
      @(posedge clock);
    chk({5'h0, op_state}, {5'h0, st});
    repeat (2) @(posedge clock);
    chk({7'h0, interrupt_out_n}, 8'h00);
    rd(8'h03, 8'h04);
    repeat (2) @(posedge clock);
    chk({7'h0, interrupt_out_n}, 8'h01);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // results take the oldest note of their stream
  always @(posedge clock) begin
    if (pend)
      chk(reg_rdata, rq.pop_front());
    pend = reg_rd;
    if (tx_valid && tx_ready)
      chk(tx_byte, tq.pop_front());
  end
  // hang guard, well past the expected few hundred cycles
  initial begin
    #400us;
    err_count++;
    wrap_up();
  end
  initial begin
    {rstn, reg_wr, reg_rd, pend, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    for (int k = 0; k < 7; k++)
      rd(regs[k], rsts[k]);
    $display("register reset test done");
    wr(8'h7D, 8'h00);
    wr(8'h05, 8'h04);
    wr(8'h30, 8'h00);
    push(2);
    tx(8'h09, 3'h1, 2);
    push(2);
    tx(8'h0A, 3'h2, 2);
    push(2);
    tx(8'h08, 3'h1, 2);
    wr(8'h07, 8'h00);
    @(posedge clock);
    chk({5'h0, op_state}, 8'h00);
    $display("return state test done");
    wr(8'h30, 8'h08);
    wr(8'h33, 8'h0A);
    wr(8'h3E, 8'h02);
    push(4);
    tx(8'h09, 3'h1, 2);
    // host re-enters tx for the rest
    tx(8'h09, 3'h1, 2);
    $display("packet length test done");
    wr(8'h7C, 8'h03);
    wr(8'h05, 8'h40);
    push(3);
    pq.delete();
    repeat (2) @(posedge clock);
    chk({7'h0, interrupt_out_n}, 8'h00);
    rd(8'h03, 8'h40);
    wr(8'h80, 8'h01);
    wr(8'h80, 8'h00);
    $display("tx threshold test done");
    wr(8'h7E, 8'h02);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h04);
    for (int f = 0; f < 2; f++) begin
      modem_model_i.frame(1'b1);
      repeat (3) begin
        b = rnd();
        sq.push_back(b);
        modem_model_i.send(b);
      end
      modem_model_i.frame(1'b0);
      chk({7'h0, interrupt_out_n}, {7'h0, f == 0});
      rd(8'h03, 8'h10);
      if (f == 0) begin
        repeat (3) rd(8'h7F, sq.pop_front());
        wr(8'h05, 8'h10);
      end
    end
    wr(8'h80, 8'h02);
    wr(8'h80, 8'h00);
    rd(8'h7F, 8'h00);
    repeat (3) @(posedge clock);
    $display("rx fifo test done");
    wrap_up();
  end
endmodule // testbench
bind radio_fifo_packet_handler radio_fifo_properties radio_fifo_properties_i (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .interrupt_out_n(interrupt_out_n), .op_state(op_state));
